// ### core/dih_map.svh
`ifndef DIH_MAP_SVH
`define DIH_MAP_SVH

// Command codes, addresses, CRC constants and accepted banks
`define DIH_CMD_INIT 4'h0
`define DIH_CMD_STATUS 4'h1
`define DIH_CMD_IMPL 16'h3e96
`define DIH_GLOBAL_ADDR 4'h0
`define DIH_EDC_ADDR 4'h0
`define DIH_CRC_SEED 4'ha
`define DIH_CRC_POLY 4'h3
`define DIH_BANK_OK 4'h3

// Data field positions
`define DIH_D_OTP_PROGRAM_ENABLE 7
`define DIH_D_BUS_SWITCH_CLOSE 6
`define DIH_D_BNK_HI 5
`define DIH_D_BNK_LO 4
`define DIH_D_ADDRESS_TO_ASSIGN_HI 3

// Software port
`define DIH_REG_CTRL 4'h0
`define DIH_REG_STATUS 4'h1
`define DIH_REG_ADDR 4'h2
`define DIH_CTRL_RST 8'h00
`define DIH_CTRL_ENH_LONG 0
`define DIH_CTRL_ENH_SHORT 1

// Timing
`define DIH_CLK_MHZ 25
`define DIH_TEST_NS 10000
`define DIH_BLANK_NS 50000
`define DIH_TEST_CYC ((`DIH_TEST_NS * `DIH_CLK_MHZ + 999) / 1000)
`define DIH_BLANK_CYC ((`DIH_BLANK_NS * `DIH_CLK_MHZ + 999) / 1000)
`endif

// ### core/dih_pkg.sv
package dih_pkg;
  typedef enum logic [1:0] {
    FMT_STD_LONG,
    FMT_STD_SHORT,
    FMT_ENH_LONG,
    FMT_ENH_SHORT
  } dih_fmt_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TEST,
    ST_BLANK,
    ST_DONE
  } dih_state_t;
endpackage : dih_pkg

// ### core/dih_crc4.sv
`timescale 1ns/1ns
`include "dih_map.svh"
module dih_crc4 #(
  parameter logic [3:0] SEED = `DIH_CRC_SEED
) (
  // Message, oldest bit at the top
  input wire logic [15:0] bits,
  input wire logic isShort,
  // Result
  output logic [3:0] crc
);
  logic [3:0] c;
  logic fb;

  // Short frames carry no data byte, so only the low eight bits count
  always_comb begin
    c = SEED;
    fb = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (!(isShort && i > 7)) begin
        fb = c[3] ^ bits[i];
        c = {c[2:0], 1'b0} ^ (fb ? `DIH_CRC_POLY : 4'h0);
      end
    end
    crc = c;
  end
endmodule : dih_crc4

// ### core/dih_init_cmd.sv
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ns
`include "dih_map.svh"
module dih_init_cmd #(
  parameter int unsigned TEST_CYC = `DIH_TEST_CYC,
  parameter int unsigned BLANK_CYC = `DIH_BLANK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Decoded frame from the link layer
  input wire logic frameValid,
  input dih_pkg::dih_fmt_t frameFormat,
  input wire logic [3:0] frameCmd,
  input wire logic [3:0] frameAddr,
  input wire logic [7:0] frameData,
  input wire logic [3:0] frameCrc,
  // Fuse mirror
  input wire logic [3:0] otpAddr,
  input wire logic otpAddrProgrammed,
  // Downstream node comparator
  input wire logic busShortHigh,
  // Software port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // Initialization results
  output logic busSwitchClose,
  output logic otpProgramEnable,
  output logic [1:0] bankSel,
  output logic busFaultFlag,
  output logic [3:0] devAddr,
  output logic initDone,
  output logic blanking,
  output logic [3:0] otpEdcAddr,
  // Response for the next transfer
  output logic respSend,
  output logic [15:0] respData,
  output logic [3:0] respCrc,
  // Commands passed on
  output logic statusReq,
  output logic cmdValid,
  output logic [3:0] cmdCode,
  output logic [7:0] cmdData
);
  dih_pkg::dih_state_t state_r;
  logic shortSync1_r, shortSync2_r;
  logic loadDone_r;
  logic [15:0] cnt_r;
  logic [7:0] ctrl_r;
  logic switch_r, busSwitchCloseReq_r, otpEn_r, fault_r, initDone_r;
  logic [1:0] bank_r;
  logic [3:0] addr_r, edcAddr_r;
  logic respPending_r, respSend_r;
  logic [15:0] respData_r;
  logic [3:0] respCrc_r;
  logic statusReq_r, cmdValid_r;
  logic [3:0] cmdCode_r;
  logic [7:0] cmdData_r;
  logic [7:0] rdData_r;

  logic isShortFmt, fmtOk, rxOk, addrOk, bankOk, initTake, cmdTake, statusTake;
  logic [3:0] rxCrc, txCrc, addressToAssign;
  logic [1:0] bankField;
  logic testEnd, faultNow;
  logic [15:0] respNext;

  // Comparator is asynchronous to clk
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shortSync1_r <= 1'b0;
      shortSync2_r <= 1'b0;
    end else begin
      shortSync1_r <= busShortHigh;
      shortSync2_r <= shortSync1_r;
    end
  end

  // Frame checks
  assign isShortFmt = (frameFormat == dih_pkg::FMT_STD_SHORT) || (frameFormat == dih_pkg::FMT_ENH_SHORT);
  dih_crc4 #(.SEED(`DIH_CRC_SEED)) uRxCrc (
    .bits({frameData, frameAddr, frameCmd}),
    .isShort(isShortFmt),
    .crc(rxCrc)
  );
  always_comb begin
    unique case (frameFormat)
      dih_pkg::FMT_STD_LONG: fmtOk = 1'b1;
      dih_pkg::FMT_STD_SHORT: fmtOk = 1'b1;
      dih_pkg::FMT_ENH_LONG: fmtOk = ctrl_r[`DIH_CTRL_ENH_LONG];
      dih_pkg::FMT_ENH_SHORT: fmtOk = ctrl_r[`DIH_CTRL_ENH_SHORT];
    endcase
  end

  // Nothing past this point looks at a field of a frame with a bad CRC
  assign rxOk = frameValid && (rxCrc == frameCrc) && fmtOk && loadDone_r;

  assign addressToAssign = frameData[`DIH_D_ADDRESS_TO_ASSIGN_HI:0];
  assign bankField = frameData[`DIH_D_BNK_HI:`DIH_D_BNK_LO];
  assign bankOk = |(4'(`DIH_BANK_OK) & (4'h1 << bankField));

  // Addressing conditions
  assign addrOk = otpAddrProgrammed ? ((frameAddr == otpAddr) && (addressToAssign == otpAddr))
    : (frameAddr == `DIH_GLOBAL_ADDR);

  assign initTake = rxOk && !initDone_r && (frameCmd == `DIH_CMD_INIT)
    && (frameFormat == dih_pkg::FMT_STD_LONG)
    && addrOk && (addressToAssign != `DIH_GLOBAL_ADDR) && bankOk;
  assign cmdTake = rxOk && initDone_r && (frameAddr == addr_r)
    && (frameCmd != `DIH_CMD_INIT) && |(16'(`DIH_CMD_IMPL) & (16'h0001 << frameCmd));
  assign statusTake = cmdTake && (frameCmd == `DIH_CMD_STATUS)
    && (addr_r != `DIH_GLOBAL_ADDR);

  // Address load after reset release, then assignment
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      loadDone_r <= 1'b0;
      addr_r <= `DIH_GLOBAL_ADDR;
    end else if (!loadDone_r) begin
      loadDone_r <= 1'b1;
      addr_r <= otpAddrProgrammed ? otpAddr : `DIH_GLOBAL_ADDR;
    end else if (initTake) begin
      addr_r <= addressToAssign;
    end
  end

  // Error detection of the fuse array never follows the run-time address
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      edcAddr_r <= `DIH_EDC_ADDR;
    end else begin
      edcAddr_r <= `DIH_EDC_ADDR;
    end
  end

  // Latched settings
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      initDone_r <= 1'b0;
      busSwitchCloseReq_r <= 1'b0;
      otpEn_r <= 1'b0;
      bank_r <= 2'h0;
    end else if (initTake) begin
      initDone_r <= 1'b1;
      busSwitchCloseReq_r <= frameData[`DIH_D_BUS_SWITCH_CLOSE];
      otpEn_r <= frameData[`DIH_D_OTP_PROGRAM_ENABLE];
      bank_r <= bankField;
    end
  end

  // Bus test and blanking sequence
  assign testEnd = (state_r == dih_pkg::ST_TEST) && (cnt_r == 16'(TEST_CYC - 1));
  assign faultNow = fault_r | shortSync2_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= dih_pkg::ST_IDLE;
      cnt_r <= 16'h0000;
    end else begin
      unique case (state_r)
        dih_pkg::ST_IDLE: begin
          cnt_r <= 16'h0000;
          if (initTake) begin
            state_r <= dih_pkg::ST_TEST;
          end
        end
        dih_pkg::ST_TEST: begin
          cnt_r <= cnt_r + 16'h0001;
          if (testEnd) begin
            cnt_r <= 16'h0000;
            state_r <= (busSwitchCloseReq_r && !faultNow) ? dih_pkg::ST_BLANK : dih_pkg::ST_DONE;
          end
        end
        dih_pkg::ST_BLANK: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == 16'(BLANK_CYC - 1)) begin
            state_r <= dih_pkg::ST_DONE;
          end
        end
        dih_pkg::ST_DONE: cnt_r <= 16'h0000;
      endcase
    end
  end

  // Fault is sticky over the whole test window; a short glitch still counts
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_r <= 1'b0;
    end else if (state_r == dih_pkg::ST_TEST) begin
      fault_r <= faultNow;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      switch_r <= 1'b0;
    end else if (testEnd) begin
      switch_r <= busSwitchCloseReq_r && !faultNow;
    end
  end

  // Response
  assign respNext = {addr_r, 3'b000, faultNow, otpEn_r, busSwitchCloseReq_r, bank_r, addr_r};
  dih_crc4 #(.SEED(`DIH_CRC_SEED)) uTxCrc (
    .bits(respNext),
    .isShort(1'b0),
    .crc(txCrc)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      respData_r <= 16'h0000;
      respCrc_r <= 4'h0;
    end else if (testEnd) begin
      respData_r <= respNext;
      respCrc_r <= txCrc;
    end
  end

  // One attempt, in the transfer that follows
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      respPending_r <= 1'b0;
      respSend_r <= 1'b0;
    end else begin
      respSend_r <= frameValid && respPending_r;
      if (testEnd) begin
        respPending_r <= 1'b1;
      end else if (frameValid) begin
        respPending_r <= 1'b0;
      end
    end
  end

  // Accepted commands for the rest of the device; status data is not passed
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmdValid_r <= 1'b0;
      statusReq_r <= 1'b0;
      cmdCode_r <= 4'h0;
      cmdData_r <= 8'h00;
    end else begin
      cmdValid_r <= cmdTake && (frameCmd != `DIH_CMD_STATUS);
      statusReq_r <= statusTake;
      if (cmdTake) begin
        cmdCode_r <= frameCmd;
        cmdData_r <= (frameCmd == `DIH_CMD_STATUS) ? 8'h00 : frameData;
      end
    end
  end

  // Software port
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `DIH_CTRL_RST;
    end else if (regWr && regAddr == `DIH_REG_CTRL) begin
      ctrl_r <= {6'h00, regWrData[1:0]};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdData_r <= 8'h00;
    end else if (regRd) begin
      unique case (regAddr)
        `DIH_REG_CTRL: rdData_r <= ctrl_r;
        `DIH_REG_STATUS: rdData_r <= {1'b0, bank_r, otpEn_r, blanking, switch_r, fault_r, initDone_r};
        `DIH_REG_ADDR: rdData_r <= {4'h0, addr_r};
        default: rdData_r <= 8'h00;
      endcase
    end else begin
      rdData_r <= 8'h00;
    end
  end

  // Outputs
  assign regRdData = rdData_r;
  assign busSwitchClose = switch_r;
  assign otpProgramEnable = otpEn_r;
  assign bankSel = bank_r;
  assign busFaultFlag = fault_r;
  assign devAddr = addr_r;
  assign initDone = initDone_r;
  assign blanking = (state_r == dih_pkg::ST_BLANK);
  assign otpEdcAddr = edcAddr_r;
  assign respSend = respSend_r;
  assign respData = respData_r;
  assign respCrc = respCrc_r;
  assign statusReq = statusReq_r;
  assign cmdValid = cmdValid_r;
  assign cmdCode = cmdCode_r;
  assign cmdData = cmdData_r;

  // Checks
  logic [15:0] blankLen_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      blankLen_r <= 16'h0000;
    end else begin
      blankLen_r <= blanking ? blankLen_r + 16'h0001 : 16'h0000;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  sequence s_closeStart;
    $rose(busSwitchClose);
  endsequence
  sequence s_blankRun;
    blanking ##1 blanking;
  endsequence

  property p_initFmt;
    frameValid && !initDone_r && frameFormat != dih_pkg::FMT_STD_LONG |=> !initDone_r;
  endproperty
  a_initFmt: assert property (p_initFmt) else $error("init taken in wrong format");
  property p_preInit;
    frameValid && !initDone_r |=> !cmdValid && !statusReq;
  endproperty
  a_preInit: assert property (p_preInit) else $error("command taken before init");
  property p_resetAddr;
    $rose(loadDone_r) |-> devAddr == ($past(otpAddrProgrammed) ? $past(otpAddr) : 4'h0);
  endproperty
  a_resetAddr: assert property (p_resetAddr) else $error("reset address wrong");
  property p_switchOk;
    busSwitchClose |-> !busFaultFlag && busSwitchCloseReq_r;
  endproperty
  a_switchOk: assert property (p_switchOk) else $error("switch closed on fault");
  property p_blankStart;
    s_closeStart |-> s_blankRun;
  endproperty
  a_blankStart: assert property (p_blankStart) else $error("no blanking after close");
  property p_blankLen;
    $fell(blanking) |-> blankLen_r == 16'(BLANK_CYC);
  endproperty
  a_blankLen: assert property (p_blankLen) else $error("blanking length wrong");
  property p_noReinit;
    initDone_r |=> devAddr == $past(devAddr) && initDone_r;
  endproperty
  a_noReinit: assert property (p_noReinit) else $error("address changed after init");
  property p_respFields;
    respSend |-> respData[11:9] == 3'b000 && respData[15:12] == respData[3:0] && respData[8] == busFaultFlag;
  endproperty
  a_respFields: assert property (p_respFields) else $error("response layout wrong");
  property p_oneResp;
    respSend |-> $past(frameValid) ##1 !respSend;
  endproperty
  a_oneResp: assert property (p_oneResp) else $error("response not single");
  property p_zeroPa;
    frameValid && !initDone_r && frameData[3:0] == 4'h0 |=> !initDone_r;
  endproperty
  a_zeroPa: assert property (p_zeroPa) else $error("zero address assigned");
  property p_crcBad;
    frameValid && rxCrc != frameCrc |=> !cmdValid && !statusReq && $stable(initDone_r);
  endproperty
  a_crcBad: assert property (p_crcBad) else $error("bad crc frame acted on");
  property p_statusGlobal;
    statusReq |-> devAddr != 4'h0;
  endproperty
  a_statusGlobal: assert property (p_statusGlobal) else $error("status at global address");
endmodule : dih_init_cmd

// ### tb/dih_master.sv
`timescale 1ns/1ns
module dih_master (
  // Clock
  input wire logic clk,
  // Decoded frame towards the device
  output logic frameValid,
  output dih_pkg::dih_fmt_t frameFormat,
  output logic [3:0] frameCmd,
  output logic [3:0] frameAddr,
  output logic [7:0] frameData,
  output logic [3:0] frameCrc
);
  initial begin
    frameValid = 1'b0;
    frameFormat = dih_pkg::FMT_STD_LONG;
    frameCmd = 4'h0;
    frameAddr = 4'h0;
    frameData = 8'h00;
    frameCrc = 4'h0;
  end

  // Serial x^4+x+1, seed 4'ha, oldest bit first
  function automatic logic [3:0] crc4(input logic [15:0] m, input int n);
    logic [3:0] c;
    logic fb;
    c = 4'ha;
    for (int i = 15; i >= 16 - n; i--) begin
      fb = c[3] ^ m[i];
      c = {c[2:0], 1'b0} ^ (fb ? 4'h3 : 4'h0);
    end
    return c;
  endfunction : crc4

  // Fields are scrambled after the frame so a stale bus never looks valid
  task automatic send(input dih_pkg::dih_fmt_t fmt, input logic [3:0] cmd, input logic [3:0] addr,
                      input logic [7:0] data, input logic bad);
    logic isShort;
    logic [3:0] c;
    isShort = (fmt == dih_pkg::FMT_STD_SHORT) || (fmt == dih_pkg::FMT_ENH_SHORT);
    c = isShort ? crc4({addr, cmd, 8'h00}, 8) : crc4({data, addr, cmd}, 16);
    @(posedge clk);
    frameValid <= 1'b1;
    frameFormat <= fmt;
    frameCmd <= cmd;
    frameAddr <= addr;
    frameData <= data;
    frameCrc <= c ^ {3'b000, bad};
    @(posedge clk);
    frameValid <= 1'b0;
    frameFormat <= dih_pkg::dih_fmt_t'(~fmt);
    frameCmd <= ~cmd;
    frameAddr <= ~addr;
    frameData <= ~data;
    frameCrc <= ~c;
  endtask : send
endmodule : dih_master

// ### tb/dsi_init_command_handler_bench.sv
`timescale 1ns/1ns
`include "dih_map.svh"
module dsi_init_command_handler_bench;
  localparam int BLANK = 6;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] otpAddr = 4'h0;
  logic otpAddrProgrammed = 1'b0;
  logic busShortHigh = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData;
  logic frameValid;
  dih_pkg::dih_fmt_t frameFormat;
  logic [3:0] frameCmd, frameAddr, frameCrc, devAddr, otpEdcAddr, respCrc, cmdCode;
  logic [7:0] frameData, cmdData, rd;
  logic busSwitchClose, otpProgramEnable, busFaultFlag, initDone, blanking, respSend, statusReq, cmdValid;
  logic [1:0] bankSel;
  logic [15:0] respData;
  int fail_count = 0;
  int comparisons = 0;
  int respCount = 0;
  int accCount = 0;
  int cycles = 0;
  int r, a;

  always #20 clk = ~clk;

  dih_master mst (.clk(clk), .frameValid(frameValid), .frameFormat(frameFormat), .frameCmd(frameCmd),
    .frameAddr(frameAddr), .frameData(frameData), .frameCrc(frameCrc));

  dih_init_cmd #(.TEST_CYC(4), .BLANK_CYC(BLANK)) dut (.clk(clk), .arst_n(arst_n), .frameValid(frameValid),
    .frameFormat(frameFormat), .frameCmd(frameCmd), .frameAddr(frameAddr), .frameData(frameData),
    .frameCrc(frameCrc), .otpAddr(otpAddr), .otpAddrProgrammed(otpAddrProgrammed), .busShortHigh(busShortHigh),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .busSwitchClose(busSwitchClose), .otpProgramEnable(otpProgramEnable), .bankSel(bankSel),
    .busFaultFlag(busFaultFlag), .devAddr(devAddr), .initDone(initDone), .blanking(blanking),
    .otpEdcAddr(otpEdcAddr), .respSend(respSend), .respData(respData), .respCrc(respCrc),
    .statusReq(statusReq), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData));

  // Pulses are counted here so no check depends on landing in the right cycle
  always @(posedge clk) begin
    cycles++;
    if (respSend === 1'b1) respCount++;
    if (statusReq === 1'b1 || cmdValid === 1'b1) accCount++;
    if (cycles == 5000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task report_and_stop;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  task do_reset(input logic prog, input logic [3:0] adr);
    @(posedge clk);
    arst_n <= 1'b0;
    otpAddrProgrammed <= prog;
    otpAddr <= adr;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : do_reset

  task settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task reg_write(input logic [3:0] adr, input logic [7:0] d);
    @(posedge clk);
    regAddr <= adr;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : reg_write

  // Read data stands only in the cycle after the strobe
  task reg_read(input logic [3:0] adr, output logic [7:0] d);
    @(posedge clk);
    regAddr <= adr;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask : reg_read

  task t_start;
    settle;
    chk({12'h000, devAddr}, 16'h0000);
    chk({12'h000, otpEdcAddr}, 16'h0000);
    reg_read(`DIH_REG_CTRL, rd);
    chk({8'h00, rd}, 16'h0000);
    reg_read(4'hf, rd);
    chk({8'h00, rd}, 16'h0000);
  endtask : t_start

  task t_refused;
    r = respCount;
    mst.send(dih_pkg::FMT_STD_SHORT, 4'h0, 4'h0, 8'h05, 1'b0);
    mst.send(dih_pkg::FMT_STD_LONG, 4'h0, 4'h0, 8'h05, 1'b1);
    mst.send(dih_pkg::FMT_STD_LONG, 4'h0, 4'h3, 8'h45, 1'b0);
    mst.send(dih_pkg::FMT_STD_LONG, 4'h0, 4'h0, 8'h40, 1'b0);
    mst.send(dih_pkg::FMT_STD_LONG, 4'h0, 4'h0, 8'h25, 1'b0);
    mst.send(dih_pkg::FMT_STD_LONG, 4'h1, 4'h0, 8'h00, 1'b0);
    settle;
    chk({15'h0000, initDone}, 16'h0000);
    chk({15'h0000, busSwitchClose}, 16'h0000);
    chk(16'(respCount - r), 16'h0000);
    chk(16'(accCount), 16'h0000);
  endtask : t_refused

  task t_good;
    int b;
    mst.send(dih_pkg::FMT_STD_LONG, 4'h0, 4'h0, 8'hd5, 1'b0);
    settle;
    chk({15'h0000, initDone}, 16'h0001);
    chk({12'h000, devAddr}, 16'h0005);
    chk({14'h0000, bankSel}, 16'h0001);
    chk({15'h0000, otpProgramEnable}, 16'h0001);
    for (int i = 0; i < 40 && blanking !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk({15'h0000, busSwitchClose}, 16'h0001);
    chk({15'h0000, busFaultFlag}, 16'h0000);
    chk(respData, 16'h50d5);
    chk({12'h000, respCrc}, {12'h000, mst.crc4(16'h50d5, 16)});
    b = 0;
    while (blanking === 1'b1 && b < 40) begin
      @(posedge clk);
      #1;
      b++;
    end
    chk(b[15:0], BLANK[15:0]);
    r = respCount;
    a = accCount;
    mst.send(dih_pkg::FMT_STD_LONG, 4'h1, 4'h5, 8'h3c, 1'b0);
    settle;
    chk(16'(respCount - r), 16'h0001);
    chk(16'(accCount - a), 16'h0001);
    chk({12'h000, cmdCode}, 16'h0001);
    chk({8'h00, cmdData}, 16'h0000);
    mst.send(dih_pkg::FMT_STD_LONG, 4'h0, 4'h5, 8'h53, 1'b0);
    mst.send(dih_pkg::FMT_STD_LONG, 4'h3, 4'h5, 8'h00, 1'b0);
    mst.send(dih_pkg::FMT_STD_LONG, 4'h1, 4'h6, 8'h00, 1'b0);
    settle;
    chk({12'h000, devAddr}, 16'h0005);
    chk(16'(respCount - r), 16'h0001);
    chk(16'(accCount - a), 16'h0001);
  endtask : t_good

  task t_enh;
    a = accCount;
    mst.send(dih_pkg::FMT_ENH_LONG, 4'h1, 4'h5, 8'h00, 1'b0);
    settle;
    chk(16'(accCount - a), 16'h0000);
    reg_write(`DIH_REG_CTRL, 8'hff);
    reg_read(`DIH_REG_CTRL, rd);
    chk({8'h00, rd}, 16'h0003);
    reg_read(`DIH_REG_ADDR, rd);
    chk({8'h00, rd}, 16'h0005);
    mst.send(dih_pkg::FMT_ENH_LONG, 4'h1, 4'h5, 8'h00, 1'b0);
    mst.send(dih_pkg::FMT_ENH_SHORT, 4'h1, 4'h5, 8'h00, 1'b0);
    mst.send(dih_pkg::FMT_STD_SHORT, 4'h1, 4'h5, 8'h00, 1'b0);
    settle;
    chk(16'(accCount - a), 16'h0003);
    a = accCount;
    mst.send(dih_pkg::FMT_STD_LONG, 4'h2, 4'h5, 8'h81, 1'b0);
    settle;
    chk(16'(accCount - a), 16'h0001);
    chk({12'h000, cmdCode}, 16'h0002);
    chk({8'h00, cmdData}, 16'h0081);
  endtask : t_enh

  task t_fault;
    @(posedge clk);
    busShortHigh <= 1'b1;
    do_reset(1'b1, 4'h9);
    #1;
    chk({12'h000, devAddr}, 16'h0009);
    mst.send(dih_pkg::FMT_STD_LONG, 4'h0, 4'h9, 8'h43, 1'b0);
    settle;
    chk({15'h0000, initDone}, 16'h0000);
    mst.send(dih_pkg::FMT_STD_LONG, 4'h0, 4'h9, 8'h49, 1'b0);
    for (int i = 0; i < 40 && busFaultFlag !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk({15'h0000, busFaultFlag}, 16'h0001);
    // The test window is still running here; wait for its end
    repeat (4) @(posedge clk);
    #1;
    chk({15'h0000, busSwitchClose}, 16'h0000);
    chk({15'h0000, blanking}, 16'h0000);
    chk(respData, 16'h9149);
    chk({12'h000, respCrc}, {12'h000, mst.crc4(16'h9149, 16)});
    reg_read(`DIH_REG_STATUS, rd);
    chk({8'h00, rd}, 16'h0003);
  endtask : t_fault

  initial begin
    do_reset(1'b0, 4'h0);
    t_start;
    t_refused;
    t_good;
    t_enh;
    t_fault;
    report_and_stop;
  end
endmodule : dsi_init_command_handler_bench
